/* File: logic/edge_port_defines.svh */
// register offsets, reset values and select codes of the edge port
`ifndef EDGE_PORT_DEFINES_SVH
`define EDGE_PORT_DEFINES_SVH

`define ADDR_W 12
`define OFF_EDGE_SELECT 12'h000
`define OFF_PIN_DIRECTION 12'h004
`define OFF_IRQ_ENABLE 12'h008
`define OFF_OUTPUT_DATA 12'h00C
`define OFF_PIN_LEVEL 12'h010
`define OFF_EDGE_FLAGS 12'h014

`define RST_EDGE_SELECT 14'h0000
`define RST_PIN_DIRECTION 7'h00
`define RST_IRQ_ENABLE 7'h00
`define RST_OUTPUT_DATA 7'h7F
`define RST_EDGE_FLAGS 7'h00

`define SEL_LEVEL 2'h0
`define SEL_BOTH 2'h3

`endif

/* File: logic/edge_port_pkg.sv */
// shared types of the edge port
package edge_port_pkg;

  typedef logic [1:0] edge_sel_t;
  typedef logic [31:0] bus_word_t;

endpackage : edge_port_pkg

/* File: logic/pin_sync.sv */
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps

module pin_sync #(
  parameter int WIDTH = 7
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // no reset: pin levels are reported whatever reset does
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end

endmodule : pin_sync

/* File: logic/edge_flag_cell.sv */
// edge detector and sticky flag of one pin
`timescale 1ns/10ps
`include "edge_port_defines.svh"

module edge_flag_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic armed,
  input wire logic level_prev,
  input wire logic level_now,
  input wire edge_port_pkg::edge_sel_t mode,
  input wire logic clear,
  output logic flag
);

  logic falling;
  logic rising;
  logic edge_hit;
  logic next_flag;

  assign falling = level_prev & ~level_now;
  assign rising = ~level_prev & level_now;

  // code 10 acts as falling edge, like 01
  assign edge_hit = armed & (mode != `SEL_LEVEL) &
    (falling | (rising & (mode == `SEL_BOTH)));

  // an edge in the clearing cycle wins, so no event is lost
  assign next_flag = edge_hit | (flag & ~clear);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    flag && !clear |=> flag)
    else $error("flag dropped without a one written");

  a_level_no_flag: assert property (@(posedge clk) disable iff (!rst_n)
    !flag && mode == `SEL_LEVEL |=> !flag)
    else $error("flag set while pin is level sensitive");

  a_edge_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
    armed && mode != `SEL_LEVEL && level_prev && !level_now |=> flag)
    else $error("falling edge not latched");

  a_both_rising: assert property (@(posedge clk) disable iff (!rst_n)
    armed && mode == `SEL_BOTH && !level_prev && level_now |=> flag)
    else $error("rising edge not latched in both-edge mode");

endmodule : edge_flag_cell

/* File: logic/edge_port_unit.sv */
// edge port: pin interrupts, output data, pin levels and edge flags on apb
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "edge_port_defines.svh"

// Function
// - enabled pin requests while its flag set
// - enabled level pin requests while pin low
// - enable clear drops request; reset clears enables
// - stored data driven on output pins
// - data register reads stored value
// - reset sets all data bits
// - level register reads live pin levels
// - level register ignores writes; reset irrelevant
// - selected edge sets flag, any direction
// - flag sticky until one written
// - level mode never changes flag
// - reset clears all flags
// - select 00 level, 01 falling, 11 both
// - level pins are active low
// - direction one output, zero input

module edge_port_unit #(
  parameter int PINS = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PINS:1] ext_irq_pin_in,
  output logic [PINS:1] ext_irq_pin_out,
  output logic [PINS:1] ext_irq_pin_oe_n,
  output logic [PINS:1] pin_irq_req,
  output logic irq
);

  // registers
  logic [2*PINS+1:2] edge_select;
  logic [PINS:1] pin_direction;
  logic [PINS:1] irq_enable;
  logic [PINS:1] output_data;
  logic [PINS:1] edge_flags;

  // pin side
  logic [PINS:1] level_sync;
  logic [PINS:1] level_prev;
  logic [PINS:1] level_mode;
  logic primed;

  // bus side
  logic setup;
  logic access;
  logic wr_en;
  logic hit_sel;
  logic hit_dir;
  logic hit_ie;
  logic hit_od;
  logic hit_lvl;
  logic hit_fl;
  logic mapped;
  logic wr_sel;
  logic wr_dir;
  logic wr_ie;
  logic wr_od;
  logic wr_fl;
  logic [PINS:1] wdata_pins;
  logic [PINS:1] flag_clear;
  edge_port_pkg::bus_word_t read_word;

  // pin bits sit at 1 upward, bit 0 and the rest read as zero
  function automatic edge_port_pkg::bus_word_t place_pins(input logic [PINS:1] v);
    place_pins = {{(31-PINS){1'b0}}, v, 1'b0};
  endfunction : place_pins

  function automatic logic is_level(input edge_port_pkg::edge_sel_t sel);
    is_level = (sel == `SEL_LEVEL);
  endfunction : is_level

  // synchronised pin levels

  pin_sync #(
    .WIDTH(PINS)
  ) u_pin_sync (
    .clk(pclk),
    .d(ext_irq_pin_in),
    .q(level_sync)
  );

  // previous level for edge detection; no reset, like the levels
  always_ff @(posedge pclk) begin
    level_prev <= level_sync;
  end

  // edges are ignored for the first cycle after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
    end
  end

  // apb decode

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_en = access & pwrite;

  assign hit_sel = (paddr == `OFF_EDGE_SELECT);
  assign hit_dir = (paddr == `OFF_PIN_DIRECTION);
  assign hit_ie = (paddr == `OFF_IRQ_ENABLE);
  assign hit_od = (paddr == `OFF_OUTPUT_DATA);
  assign hit_lvl = (paddr == `OFF_PIN_LEVEL);
  assign hit_fl = (paddr == `OFF_EDGE_FLAGS);
  assign mapped = hit_sel | hit_dir | hit_ie | hit_od | hit_lvl | hit_fl;

  assign wr_sel = wr_en & hit_sel;
  assign wr_dir = wr_en & hit_dir;
  assign wr_ie = wr_en & hit_ie;
  assign wr_od = wr_en & hit_od;
  assign wr_fl = wr_en & hit_fl;

  // bit 0 is dropped on every write, whatever software puts there
  assign wdata_pins = pwdata[PINS:1];

  // zero wait states; only unmapped addresses fail
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  assign read_word =
    hit_sel ? {{(30-2*PINS){1'b0}}, edge_select, 2'b00} :
    hit_dir ? place_pins(pin_direction) :
    hit_ie ? place_pins(irq_enable) :
    hit_od ? place_pins(output_data) :
    hit_lvl ? place_pins(level_sync) :
    hit_fl ? place_pins(edge_flags) :
    32'h0000_0000;

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata <= read_word;
    end
  end

  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_select <= `RST_EDGE_SELECT;
    end else if (wr_sel) begin
      edge_select <= pwdata[2*PINS+1:2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction <= `RST_PIN_DIRECTION;
    end else if (wr_dir) begin
      pin_direction <= wdata_pins;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= `RST_IRQ_ENABLE;
    end else if (wr_ie) begin
      irq_enable <= wdata_pins;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_data <= `RST_OUTPUT_DATA;
    end else if (wr_od) begin
      output_data <= wdata_pins;
    end
  end

  // the pin level register has no storage, so writes fall away
  assign flag_clear = wr_fl ? wdata_pins : '0;

  // per-pin flags

  for (genvar i = 1; i <= PINS; i++) begin : g_pin
    assign level_mode[i] = is_level(edge_select[2*i+1:2*i]);

    edge_flag_cell u_cell (
      .clk(pclk),
      .rst_n(presetn),
      .armed(primed),
      .level_prev(level_prev[i]),
      .level_now(level_sync[i]),
      .mode(edge_select[2*i+1:2*i]),
      .clear(flag_clear[i]),
      .flag(edge_flags[i])
    );
  end

  // pins and requests

  // direction one drives the pin; oe_n low while driving
  assign ext_irq_pin_out = output_data;
  assign ext_irq_pin_oe_n = ~pin_direction;

  // level requests are not latched: they follow the low pin
  assign pin_irq_req = irq_enable & (edge_flags | (level_mode & ~level_sync));

  // flags are the sticky status and enables the mask of the single line
  assign irq = |pin_irq_req;

  // checks

  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  sequence s_read_odata;
    setup && !pwrite && hit_od;
  endsequence

  sequence s_read_level;
    setup && !pwrite && hit_lvl;
  endsequence

  sequence s_write_level;
    access && pwrite && hit_lvl;
  endsequence

  sequence s_write_flags;
    access && pwrite && hit_fl;
  endsequence

  sequence s_read_unmapped;
    setup && !pwrite && !mapped;
  endsequence

  sequence s_write_unmapped;
    access && pwrite && !mapped;
  endsequence

  a_flag_request: assert property (
    ((edge_flags & irq_enable & ~pin_irq_req) == '0) && ((edge_flags & irq_enable) == '0 || irq))
    else $error("enabled flag without request");

  a_level_request: assert property (
    (irq_enable & level_mode & ~level_sync & ~pin_irq_req) == '0)
    else $error("enabled low level pin without request");

  a_level_unlatched: assert property (
    (irq_enable & level_mode & ~edge_flags & level_sync & pin_irq_req) == '0)
    else $error("high level pin still requesting");

  a_enable_clear: assert property (
    wr_ie |=> (pin_irq_req & ~$past(wdata_pins)) == '0)
    else $error("request survives cleared enable");

  a_reset_state: assert property (
    $rose(presetn) |-> irq_enable == '0 && output_data == '1 && edge_flags == '0 && !irq)
    else $error("wrong state after reset");

  a_odata_drive: assert property (
    wr_od |=> output_data == $past(wdata_pins) && ext_irq_pin_out == $past(wdata_pins))
    else $error("written data not driven");

  a_odata_read: assert property (
    s_read_odata |=> prdata == place_pins(output_data) && access)
    else $error("data read differs from stored value");

  a_level_read: assert property (
    s_read_level |=> prdata == place_pins($past(level_sync)))
    else $error("level read differs from pin");

  a_level_write: assert property (
    s_write_level |-> !pslverr && pready ##1
    $stable(irq_enable) && $stable(output_data) && $stable(pin_direction))
    else $error("level write altered state or failed");

  a_dir_enable: assert property (
    wr_dir |=> ext_irq_pin_oe_n == ~$past(wdata_pins))
    else $error("direction not applied");

  a_flag_clear: assert property (
    wr_fl && level_sync == level_prev |=> (edge_flags & $past(wdata_pins)) == '0)
    else $error("flag not cleared by one");

  a_unmapped_err: assert property (
    access && !mapped |-> pslverr)
    else $error("unmapped access accepted");

  a_flag_keep: assert property (
    s_write_flags |=> ($past(edge_flags) & ~$past(wdata_pins) & ~edge_flags) == '0)
    else $error("flag lost where zero written");

  a_sel_write: assert property (
    wr_sel |=> edge_select == $past(pwdata[2*PINS+1:2]))
    else $error("edge select not stored");

  a_ie_write: assert property (
    wr_ie |=> irq_enable == $past(wdata_pins))
    else $error("enable not stored");

  a_unmapped_rdata: assert property (
    s_read_unmapped |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_unmapped_quiet: assert property (
    s_write_unmapped |=> $stable(edge_select) && $stable(pin_direction) &&
    $stable(irq_enable) && $stable(output_data))
    else $error("unmapped write altered state");

  a_level_quiet: assert property (
    (edge_flags & ~$past(edge_flags) & $past(level_mode)) == '0)
    else $error("flag raised on level pin");

  a_prdata_hold: assert property (
    !(setup && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");

  // raw pin watched, so the synchroniser delay is part of the check
  for (genvar k = 1; k <= PINS; k++) begin : g_chk
    sequence s_low_held;
      (!ext_irq_pin_in[k] && irq_enable[k] && level_mode[k]) [*3];
    endsequence

    sequence s_high_held;
      (ext_irq_pin_in[k] && level_mode[k] && !edge_flags[k]) [*3];
    endsequence

    a_low_request: assert property (s_low_held |-> pin_irq_req[k])
      else $error("low level pin without request");

    a_high_quiet: assert property (s_high_held |-> !pin_irq_req[k])
      else $error("high level pin requesting");
  end

endmodule : edge_port_unit

/* File: dv/pin_source_model.sv */
// far side of the pins: external sources, overridden where the port drives
`timescale 1ns/10ps

module pin_source_model (
  input wire logic [7:1] src,
  input wire logic [7:1] drv,
  input wire logic [7:1] drv_oe_n,
  output wire logic [7:1] pin
);
  // a driven pin shows the port data, else the outside source
  assign pin = (drv_oe_n & src) | (~drv_oe_n & drv);
endmodule : pin_source_model

/* File: dv/edge_port_unit_bench.sv */
// self-checking bench of the edge port over apb
`timescale 1ns/10ps
`include "edge_port_defines.svh"

module edge_port_unit_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:1] src, pout, poe_n, preq;
  wire [7:1] pw;
  int miscompares, checks;

  edge_port_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin_in(pw), .ext_irq_pin_out(pout),
    .ext_irq_pin_oe_n(poe_n), .pin_irq_req(preq), .irq(irq));
  pin_source_model u_pins (.src(src), .drv(pout), .drv_oe_n(poe_n), .pin(pw));

  always #5 pclk = ~pclk;

  task automatic print_verdict;
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // bit 0 always written as zero
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d & 32'h000000FE);
  endtask : wr

  task automatic rdc(input string nm, input logic [`ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    check(nm, rd, e);
  endtask : rdc

  // sync needs two edges and the flag one more
  task automatic pin_set(input int n, input logic v);
    @(posedge pclk);
    src[n] <= v;
    repeat (4) @(posedge pclk);
    #1;
  endtask : pin_set

  task automatic test_reset;
    check("pin_out", {25'h0, pout}, 32'h0000007F);
    rdc("enable", `OFF_IRQ_ENABLE, 32'h00000000);
    rdc("data", `OFF_OUTPUT_DATA, 32'h000000FE);
    rdc("flags", `OFF_EDGE_FLAGS, 32'h00000000);
    rdc("level", `OFF_PIN_LEVEL, 32'h000000FE);
    apb(1'b0, 12'hFF0, 32'h00000000);
    check("unmapped", {31'h0, err}, 32'h00000001);
    apb(1'b1, 12'hFF0, 32'h000000FE);
    check("unmapped_wr", {31'h0, err}, 32'h00000001);
  endtask : test_reset

  task automatic test_output;
    wr(`OFF_OUTPUT_DATA, 32'h000000A8);
    wr(`OFF_PIN_DIRECTION, 32'h000000FE);
    src <= 7'h00;
    repeat (3) @(posedge pclk);
    check("drive", {25'h0, pw}, 32'h00000054);
    rdc("level", `OFF_PIN_LEVEL, 32'h000000A8);
    wr(`OFF_PIN_LEVEL, 32'h000000FE);
    check("ro_err", {31'h0, err}, 32'h00000000);
    wr(`OFF_PIN_DIRECTION, 32'h00000000);
    repeat (3) @(posedge pclk);
    rdc("level_in", `OFF_PIN_LEVEL, 32'h00000000);
    rdc("stored", `OFF_OUTPUT_DATA, 32'h000000A8);
    src <= 7'h7F;
    wr(`OFF_OUTPUT_DATA, 32'h000000FE);
    rdc("no_flag", `OFF_EDGE_FLAGS, 32'h00000000);
  endtask : test_output

  task automatic test_edges;
    logic [1:0] c;
    for (int i = 1; i < 4; i++) begin
      c = i[1:0];
      wr(`OFF_EDGE_SELECT, {16'h0, {7{c}}, 2'b00});
      pin_set(2, 1'b0);
      rdc("fall", `OFF_EDGE_FLAGS, 32'h00000004);
      wr(`OFF_EDGE_FLAGS, 32'h00000000);
      rdc("sticky", `OFF_EDGE_FLAGS, 32'h00000004);
      wr(`OFF_EDGE_FLAGS, 32'h00000004);
      pin_set(2, 1'b1);
      rdc("rise", `OFF_EDGE_FLAGS, (c == 2'h3) ? 32'h00000004 : 32'h00000000);
      wr(`OFF_EDGE_FLAGS, 32'h000000FE);
    end
  endtask : test_edges

  task automatic test_irq;
    wr(`OFF_EDGE_SELECT, 32'h00005554);
    wr(`OFF_IRQ_ENABLE, 32'h00000004);
    pin_set(2, 1'b0);
    check("req_late", {25'h0, preq}, 32'h00000002);
    check("irq", {31'h0, irq}, 32'h00000001);
    wr(`OFF_IRQ_ENABLE, 32'h00000000);
    #1;
    check("masked", {24'h0, preq, irq}, 32'h00000000);
    wr(`OFF_IRQ_ENABLE, 32'h00000004);
    wr(`OFF_EDGE_FLAGS, 32'h00000004);
    #1;
    check("cleared", {24'h0, preq, irq}, 32'h00000000);
    src[2] <= 1'b1;
    wr(`OFF_IRQ_ENABLE, 32'h00000020);
    wr(`OFF_OUTPUT_DATA, 32'h000000DE);
    wr(`OFF_PIN_DIRECTION, 32'h00000020);
    repeat (4) @(posedge pclk);
    #1;
    check("out_req", {25'h0, preq}, 32'h00000010);
    wr(`OFF_PIN_DIRECTION, 32'h00000000);
    wr(`OFF_EDGE_FLAGS, 32'h000000FE);
  endtask : test_irq

  task automatic test_level;
    wr(`OFF_EDGE_SELECT, 32'h00000000);
    wr(`OFF_IRQ_ENABLE, 32'h00000040);
    pin_set(6, 1'b0);
    check("lvl_req", {24'h0, preq, irq}, 32'h00000041);
    pin_set(6, 1'b1);
    check("lvl_off", {24'h0, preq, irq}, 32'h00000000);
    rdc("lvl_flag", `OFF_EDGE_FLAGS, 32'h00000000);
  endtask : test_level

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = 32'h00000000; src = 7'h7F;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    test_reset();
    test_output();
    test_edges();
    test_irq();
    test_level();
    print_verdict();
  end
endmodule : edge_port_unit_bench
